/* File: src/monitor_adc_config_results.sv */
// Purpose: converter setup, scaling and result registers behind a serial link
// Assumes: link frame of 8 command bits then 24 data bits, msb first
// Notes: link logic runs on sclk, converter and registers on ref_clk
//
// Contract
// RQ1 - temperature conversion time in bits 5..3, reset 5, eight-step time table.
// RQ2 - averaging code in bits 2..0, reset 0, 1 to 1024 samples.
// RQ3 - one averaging count applies to every active input.
// RQ4 - with averaging, results update only after the whole run.
// RQ5 - scale constant bits 14..0 writable, reset 1000h, bit 15 reads zero.
// RQ6 - scale constant converts shunt reading to current and sets its weight.
// RQ7 - drift coefficient bits 13..0 writable, reset 0, upper bits read zero.
// RQ8 - shunt result signed 20 bits in 23..4, low nibble zero.
// RQ9 - shunt unit weight depends on the input range select.
// RQ10 - bus result in 23..4, never negative, low nibble zero.
// RQ11 - shunt result at index 4, zero after reset.
// RQ12 - bus result at index 5, zero after reset.
// RQ13 - temperature result at index 6, zero after reset.
// RQ14 - drift coefficient at index 3, scale constant at index 2.
// RQ15 - bus conversion time in bits 11..9, reset 5, same table.
// RQ16 - shunt conversion time in bits 8..6, reset 5, same table.
// RQ17 - drift coefficient and die temperature correct the current.
// RQ18 - writes to reserved bits ignored, they read zero.
`timescale 1ns/1ns
module monitor_adc_config_results #(
  parameter int US_CYC = mon_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // converter side
  input wire logic input_range_sel,
  input wire logic [2:0] active_inputs,
  input wire mon_pkg::sample_t adc_sample,
  output logic [19:0] current_result
);
  mon_pkg::ref_st_t r_ff, nxt_r;
  mon_pkg::link_st_t k_ff, nxt_k;
  mon_pkg::link_cnt_t l_ff, nxt_l;
  logic [2:0] code;
  logic [3:0] sh;
  logic [10:0] n_avg;
  logic [23:0] tgt;
  logic signed [29:0] avg_sh, avg_bus;
  logic signed [25:0] avg_t;
  logic signed [19:0] vsh_use;
  logic signed [15:0] t_use, dt;
  logic signed [35:0] prod, cur_raw;
  logic signed [66:0] corr;
  logic [5:0] addr;
  logic [23:0] word;

  // ----------------------------------------
  // reference domain: sync, registers, converter
  // ----------------------------------------
  always_comb begin
    nxt_r = r_ff;
    sh = mon_pkg::AVG_SH[r_ff.cfg[mon_pkg::AVG_LSB +: 3]]; // RQ2
    n_avg = 11'(1) << sh;
    case (r_ff.ch)
      2'd0: code = r_ff.cfg[mon_pkg::SCT_LSB +: 3]; // RQ16
      2'd1: code = r_ff.cfg[mon_pkg::BCT_LSB +: 3]; // RQ15
      default: code = r_ff.cfg[mon_pkg::TCT_LSB +: 3]; // RQ1
    endcase
    tgt = 24'(mon_pkg::CONV_US[code] * US_CYC); // RQ1
    avg_sh = r_ff.acc_sh >>> sh; // RQ3
    avg_bus = r_ff.acc_bus >>> sh; // RQ3
    avg_t = r_ff.acc_t >>> sh; // RQ3
    vsh_use = active_inputs[0] ? avg_sh[19:0] : r_ff.vsh;
    t_use = active_inputs[2] ? avg_t[15:0] : r_ff.temp;
    prod = 36'(vsh_use) * 36'($signed({1'b0, r_ff.cal})); // RQ6
    cur_raw = prod >>> (mon_pkg::CUR_SH + (r_ff.rg_s ? mon_pkg::RANGE_SH : 0)); // RQ9
    dt = (t_use - mon_pkg::TEMP_25C) >>> mon_pkg::DT_SH;
    corr = (67'(cur_raw) * 67'($signed({1'b0, r_ff.drift})) * 67'(dt)) >>> mon_pkg::DRIFT_SH; // RQ17
    // two-flop synchronisers
    nxt_r.cs_m = cs_n;
    nxt_r.cs_s = r_ff.cs_m;
    nxt_r.cs_d = r_ff.cs_s;
    nxt_r.rg_m = input_range_sel;
    nxt_r.rg_s = r_ff.rg_m;
    nxt_r.oe = ~r_ff.cs_s;
    // frame start: freeze read image for the link
    if (r_ff.cs_d & ~r_ff.cs_s) begin
      nxt_r.snap[mon_pkg::ADDR_CFG] = {r_ff.cfg, 8'h00};
      nxt_r.snap[mon_pkg::ADDR_CAL] = {1'b0, r_ff.cal, 8'h00}; // RQ5
      nxt_r.snap[mon_pkg::ADDR_DRIFT] = {2'b00, r_ff.drift, 8'h00}; // RQ7
      nxt_r.snap[mon_pkg::ADDR_VSH] = {r_ff.vsh, 4'h0}; // RQ8
      nxt_r.snap[mon_pkg::ADDR_BUS_VOLTAGE_RESULT] = {r_ff.bus_voltage_result, 4'h0}; // RQ10
      nxt_r.snap[mon_pkg::ADDR_TEMP] = {r_ff.temp, 8'h00};
    end
    // frame end: commit a completed write
    if (~r_ff.cs_d & r_ff.cs_s & k_ff.wr_ok) begin
      case (k_ff.wa)
        mon_pkg::ADDR_CFG: nxt_r.cfg = k_ff.wv & mon_pkg::CFG_MASK; // RQ18
        mon_pkg::ADDR_CAL: nxt_r.cal = k_ff.wv[14:0]; // RQ14
        mon_pkg::ADDR_DRIFT: nxt_r.drift = k_ff.wv[13:0]; // RQ14
        default: nxt_r.cfg = r_ff.cfg;
      endcase
    end
    // conversion sequencer
    case (r_ff.st)
      mon_pkg::S_CONV: begin
        if (!active_inputs[r_ff.ch]) begin
          nxt_r.st = mon_pkg::S_NEXT;
        end else if (r_ff.tmr >= tgt - 24'h000001) begin
          nxt_r.tmr = '0;
          nxt_r.st = mon_pkg::S_NEXT;
          case (r_ff.ch)
            2'd0: nxt_r.acc_sh = r_ff.acc_sh + 30'(adc_sample.vsh);
            2'd1: nxt_r.acc_bus = r_ff.acc_bus + 30'(adc_sample.bus_voltage_result);
            default: nxt_r.acc_t = r_ff.acc_t + 26'(adc_sample.temp);
          endcase
        end else begin
          nxt_r.tmr = r_ff.tmr + 24'h000001;
        end
      end
      mon_pkg::S_NEXT: begin
        nxt_r.st = mon_pkg::S_CONV;
        if (r_ff.ch == 2'd2) begin
          nxt_r.ch = 2'd0;
          if (r_ff.cnt + 11'h001 == n_avg) begin
            nxt_r.st = mon_pkg::S_UPD; // RQ4
          end else begin
            nxt_r.cnt = r_ff.cnt + 11'h001;
          end
        end else begin
          nxt_r.ch = r_ff.ch + 2'd1;
        end
      end
      mon_pkg::S_UPD: begin
        if (active_inputs[0]) begin
          nxt_r.vsh = avg_sh[19:0]; // RQ4
        end
        if (active_inputs[1]) begin
          nxt_r.bus_voltage_result = avg_bus[29] ? 20'sh00000 : avg_bus[19:0]; // RQ10
        end
        if (active_inputs[2]) begin
          nxt_r.temp = avg_t[15:0];
        end
        if (active_inputs[0]) begin
          nxt_r.cur = 20'(cur_raw + 36'(corr)); // RQ17
        end
        nxt_r.cnt = '0;
        nxt_r.acc_sh = '0;
        nxt_r.acc_bus = '0;
        nxt_r.acc_t = '0;
        nxt_r.st = mon_pkg::S_CONV;
      end
      default: nxt_r.st = mon_pkg::S_CONV;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_ff <= mon_pkg::R_RST; // RQ11 RQ12 RQ13
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------
  // link domain: shift in command, shift out data
  // ----------------------------------------
  always_comb begin
    nxt_k = k_ff;
    nxt_l = l_ff;
    addr = k_ff.cmd[6:1];
    word = '0;
    if (addr >= mon_pkg::ADDR_CFG && addr <= mon_pkg::ADDR_TEMP) begin
      word = r_ff.snap[addr]; // RQ14
    end
    if (l_ff.cnt != 6'(mon_pkg::FRAME_BITS)) begin
      nxt_l.cnt = l_ff.cnt + 6'h01;
    end
    if (l_ff.cnt < 6'h08) begin
      nxt_k.cmd = {k_ff.cmd[6:0], mosi};
      if (l_ff.cnt == 6'h00) begin
        nxt_k.wr_ok = 1'b0;
      end
    end
    if (l_ff.cnt == 6'h07) begin
      nxt_l.miso = word[23];
      nxt_k.out = {word[22:0], 1'b0};
    end else if (l_ff.cnt >= 6'h08 && l_ff.cnt < 6'(mon_pkg::FRAME_BITS)) begin
      nxt_l.miso = k_ff.out[23];
      nxt_k.out = {k_ff.out[22:0], 1'b0};
      nxt_k.wd = {k_ff.wd[14:0], mosi};
    end
    if (l_ff.cnt == 6'h17 && !k_ff.cmd[0]) begin
      nxt_k.wa = k_ff.cmd[7:2];
      nxt_k.wv = {k_ff.wd[14:0], mosi};
      nxt_k.wr_ok = 1'b1;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end

  always_ff @(posedge sclk) begin
    k_ff <= nxt_k;
  end

  assign miso = l_ff.miso;
  assign miso_oe = r_ff.oe;
  assign current_result = r_ff.cur;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_CFG_RST: assert property (@(posedge ref_clk) rst |=> // RQ15
    r_ff.cfg == 16'h0b68 && r_ff.cal == 15'h1000 && r_ff.drift == 14'h0000)
    else $error("setup reset values wrong");
  AST_RES_RST: assert property (@(posedge ref_clk) rst |=> // RQ11
    r_ff.vsh == 0 && r_ff.bus_voltage_result == 0 && r_ff.temp == 0)
    else $error("results not cleared by reset");
  AST_CAL_WR: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
    (~r_ff.cs_d & r_ff.cs_s & k_ff.wr_ok && k_ff.wa == 6'h02) |=>
    r_ff.cal == $past(k_ff.wv[14:0]) && r_ff.snap[2][23] == 1'b0)
    else $error("scale constant write wrong");
  AST_CFG_RSV: assert property (@(posedge ref_clk) disable iff (rst) // RQ18
    r_ff.cfg[15:12] == 4'h0 && r_ff.snap[3][23:22] == 2'b00)
    else $error("reserved bits not zero");
  AST_AVG_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
    !$stable(r_ff.vsh) |-> $past(r_ff.st) == mon_pkg::S_UPD)
    else $error("result changed outside update");
  AST_AVG_COUNT: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
    r_ff.st == mon_pkg::S_UPD |-> r_ff.cnt == n_avg - 11'h001 && r_ff.ch == 2'd0)
    else $error("update before full averaging run");
  AST_BUS_POS: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
    $past(r_ff.st) == mon_pkg::S_UPD |-> !r_ff.bus_voltage_result[19])
    else $error("bus result negative");
  AST_CONV_TIME: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
    (r_ff.st == mon_pkg::S_NEXT && $past(r_ff.st) == mon_pkg::S_CONV
    && $past(active_inputs[r_ff.ch])) |-> $past(r_ff.tmr) >= $past(tgt) - 1)
    else $error("conversion ended early");
  AST_SHUNT_IMG: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
    (r_ff.cs_d & ~r_ff.cs_s) |=> r_ff.snap[4] == {$past(r_ff.vsh), 4'h0})
    else $error("shunt image wrong");
  AST_WR_LATCH: assert property (@(posedge sclk) disable iff (cs_n) // RQ14
    (l_ff.cnt == 6'h17 && !k_ff.cmd[0]) |=> k_ff.wr_ok && k_ff.wa == $past(k_ff.cmd[7:2]))
    else $error("write not captured");
  COV_UPD: cover property (@(posedge ref_clk) disable iff (rst)
    r_ff.st == mon_pkg::S_UPD && r_ff.cfg[2:0] != 3'h0);
  COV_WR: cover property (@(posedge ref_clk) disable iff (rst)
    ~r_ff.cs_d & r_ff.cs_s & k_ff.wr_ok);
  COV_RD: cover property (@(posedge sclk) disable iff (cs_n)
    l_ff.cnt == 6'h07 && k_ff.cmd[6]);
endmodule // monitor_adc_config_results

/* File: src/mon_pkg.sv */
// Purpose: constants and types for the monitor converter block
// Assumes: 50 MHz reference clock
// Notes: offsets are register indices on the serial link
package mon_pkg;
  localparam int CLK_MHZ = 50;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [5:0] ADDR_CFG = 6'h01;
  localparam logic [5:0] ADDR_CAL = 6'h02;
  localparam logic [5:0] ADDR_DRIFT = 6'h03;
  localparam logic [5:0] ADDR_VSH = 6'h04;
  localparam logic [5:0] ADDR_BUS_VOLTAGE_RESULT = 6'h05;
  localparam logic [5:0] ADDR_TEMP = 6'h06;
  // ----------------------------------------
  // reset values, masks, fields
  // ----------------------------------------
  localparam logic [15:0] CFG_RST = 16'h0b68;
  localparam logic [15:0] CFG_MASK = 16'h0fff;
  localparam logic [14:0] CAL_RST = 15'h1000;
  localparam int BCT_LSB = 9;
  localparam int SCT_LSB = 6;
  localparam int TCT_LSB = 3;
  localparam int AVG_LSB = 0;
  // ----------------------------------------
  // timing and scaling
  // ----------------------------------------
  localparam int CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  localparam logic [3:0] AVG_SH [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
  localparam logic signed [15:0] TEMP_25C = 16'sh0c80;
  localparam int CUR_SH = 11;
  localparam int RANGE_SH = 2;
  localparam int DT_SH = 7;
  localparam int DRIFT_SH = 20;
  localparam int FRAME_BITS = 32;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic signed [19:0] vsh;
    logic signed [19:0] bus_voltage_result;
    logic signed [15:0] temp;
  } sample_t;
  typedef enum logic [2:0] {
    S_CONV = 3'b001,
    S_NEXT = 3'b010,
    S_UPD = 3'b100
  } conv_st_t;
  typedef struct packed {
    logic cs_m, cs_s, cs_d, rg_m, rg_s, oe;
    logic [6:1][23:0] snap;
    logic [15:0] cfg;
    logic [14:0] cal;
    logic [13:0] drift;
    logic signed [19:0] vsh, bus_voltage_result, cur;
    logic signed [15:0] temp;
    conv_st_t st;
    logic [1:0] ch;
    logic [10:0] cnt;
    logic [23:0] tmr;
    logic signed [29:0] acc_sh, acc_bus;
    logic signed [25:0] acc_t;
  } ref_st_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] wd, wv;
    logic [23:0] out;
    logic [5:0] wa;
    logic wr_ok;
  } link_st_t;
  typedef struct packed {
    logic [5:0] cnt;
    logic miso;
  } link_cnt_t;
  localparam ref_st_t R_RST = '{cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1,
    cfg: CFG_RST, cal: CAL_RST, st: S_CONV, default: '0};
endpackage

/* File: bench/host_link.sv */
// Purpose: host side of the serial link, frame master
// Assumes: link clock period 160 ns, clock idle low between frames
// Notes: mosi shows the inverse of its last bit while idle
`timescale 1ns/1ns
module host_link (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // one frame: 8 command bits, 24 data bits, msb first
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] fr;
    fr = {cmd, wd};
    rd = 24'h0;
    #37 cs_n = 1'b0;
    #120;
    for (int i = 0; i < 32; i++) begin
      mosi = fr[31-i];
      #80 if (i >= 8) rd[31-i] = miso;
      sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    mosi = ~fr[0];
    #300;
  endtask
endmodule // host_link

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the monitor converter block
// Assumes: US_CYC of 1, so conversions last 50 to 4120 cycles
// Notes: host_link drives the serial link
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic [2:0] act = 3'b111;
  mon_pkg::sample_t smp = '0;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [19:0] cur, prev;
  logic [23:0] rv;
  logic signed [19:0] v;
  int fails = 0;
  int n_checks = 0;
  int n_upd = 0;
  bit cnt_on = 0;
  always #10 ref_clk = ~ref_clk;
  host_link host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  monitor_adc_config_results #(.US_CYC(1)) dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .input_range_sel(sel),
    .active_inputs(act), .adc_sample(smp), .current_result(cur));
  // ----------------------------------------
  // expectations and bus tasks
  // ----------------------------------------
  function automatic logic [23:0] rst_val(int a);
    case (a)
      1: return 24'h0b6800;
      2: return 24'h100000;
      default: return 24'h0;
    endcase
  endfunction
  function automatic logic [23:0] cur_exp(int vs, int r, int dr, int dt);
    int b;
    b = (vs * 4096) >>> (11 + 2 * r);
    b = b + ((b * dr * dt) >>> 20);
    return {4'h0, 20'(b)};
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    host.xfer({a, 2'b01}, 24'h0, rv);
    chk($sformatf("reg%0d", a), e, rv);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host.xfer({a, 2'b00}, {d, 8'h00}, rv);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic stop_test;
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // counts changes of the current result
  always @(negedge ref_clk) begin
    if (cnt_on && cur !== prev) n_upd++;
    prev = cur;
  end
  // device drives its data pin at every falling link clock edge of the frame
  always @(negedge sclk) begin
    if (!cs_n) chk("miso_oe", 24'h1, {23'h0, miso_oe});
  end
  initial begin
    #1000000;
    fails++;
    stop_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [15:0] w;
    w = 16'h0;
    void'($urandom(45));
    cyc(4);
    rst = 1'b0;
    cyc(4);
    chk("oe", 24'h0, {23'h0, miso_oe});
    for (int a = 0; a < 8; a++) rd(a[5:0], rst_val(a));
    wr(1, 16'hf001);
    rd(1, 24'h000100);
    for (int k = 0; k < 2; k++) begin
      for (int a = 2; a < 4; a++) begin
        w = k ? 16'($urandom) : 16'hffff;
        wr(a[5:0], w);
        rd(a[5:0], {w & (a == 2 ? 16'h7fff : 16'h3fff), 8'h00});
      end
    end
    wr(4, 16'hffff);
    rd(4, 24'h0);
    wr(2, 16'h1000);
    wr(3, 16'h0000);
    cyc(1);
    v = 20'($urandom_range(60000)) - 20'd30000;
    smp = {v, 20'h80000 | 20'($urandom), 16'h0c80};
    cyc(4000);
    rd(4, {v, 4'h0});
    rd(5, 24'h0);
    rd(6, {16'h0c80, 8'h00});
    chk("current", cur_exp(v, 0, 0, 0), {4'h0, cur});
    cyc(1);
    sel = 1'b1;
    cyc(2000);
    chk("current", cur_exp(v, 1, 0, 0), {4'h0, cur});
    sel = 1'b0;
    act = 3'b101;
    v = 20'($urandom_range(60000)) - 20'd30000;
    smp.vsh = v;
    smp.bus_voltage_result = 20'($urandom_range(100000));
    cyc(2000);
    rd(5, 24'h0);
    rd(4, {v, 4'h0});
    cyc(1);
    act = 3'b111;
    cyc(2000);
    rd(5, {smp.bus_voltage_result, 4'h0});
    cyc(1);
    smp.vsh = 20'sd1280;
    smp.temp = 16'h1080;
    wr(3, 16'h0400);
    cyc(2000);
    chk("current", cur_exp(1280, 0, 1024, 8), {4'h0, cur});
    cyc(1);
    cnt_on = 1'b1;
    for (int i = 0; i < 2000; i++) begin
      smp.vsh = 20'($urandom_range(4000));
      cyc(1);
    end
    cnt_on = 1'b0;
    chk("updates", 24'h1, 24'(n_upd >= 1 && n_upd <= 4));
    stop_test();
  end
endmodule // testbench
